// [logic/sdi_tx_stream_tap_status.sv]
// transmit stream tap, source select and status outputs
// Function
// - link A stream 1 tapped after payload-ID insertion
// - link A stream 2 tapped after payload-ID insertion
// - link B stream 1 tapped after payload-ID insertion
// - link B stream 2 tapped after payload-ID insertion
// - select high sends returns, low sends internal
// - cadence error high when cadence departs 5/6 in sd mode, held low outside sd mode
// - slew control high only in sd mode
// - done low during sequence, high on success
// - fail low normally, high on failed sequence
// - 3-bit failure code presented while fail high
`timescale 1ns/1ps
module sdi_tx_stream_tap_status #(
  parameter int DW = sdi_tap_pkg::DATA_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // transmit word enable and mode
  input wire logic tx_ce_i,
  input wire logic [sdi_tap_pkg::MODE_W-1:0] tx_mode_i,
  // streams from the payload-id inserter
  input wire logic [DW-1:0] ins_a1_i,
  input wire logic [DW-1:0] ins_a2_i,
  input wire logic [DW-1:0] ins_b1_i,
  input wire logic [DW-1:0] ins_b2_i,
  // taps toward the application
  output logic [DW-1:0] link_a_stream1_tap_o,
  output logic [DW-1:0] link_a_stream2_tap_o,
  output logic [DW-1:0] link_b_stream1_tap_o,
  output logic [DW-1:0] link_b_stream2_tap_o,
  // streams returned by the application
  input wire logic use_return_i,
  input wire logic [DW-1:0] link_a_stream1_return_i,
  input wire logic [DW-1:0] link_a_stream2_return_i,
  input wire logic [DW-1:0] link_b_stream1_return_i,
  input wire logic [DW-1:0] link_b_stream2_return_i,
  // streams toward the serializer
  output logic [DW-1:0] tx_a1_o,
  output logic [DW-1:0] tx_a2_o,
  output logic [DW-1:0] tx_b1_o,
  output logic [DW-1:0] tx_b2_o,
  output logic use_return_o,
  // sequence events from the reset and rate sequencer
  input wire logic seq_start_i,
  input wire logic seq_ok_i,
  input wire logic seq_fail_i,
  input wire logic [sdi_tap_pkg::CODE_W-1:0] seq_fail_code_i,
  input wire logic full_reset_i,
  // status
  output logic ce_align_err_o,
  output logic slew_o,
  output logic change_done_o,
  output logic change_fail_o,
  output logic [sdi_tap_pkg::CODE_W-1:0] change_fail_code_o
);
  // all inputs come from logic on core_clk_i, so none is synchronised here
  typedef struct packed {
    logic [3:0][DW-1:0] tap;
    logic [3:0][DW-1:0] tx;
    logic sel;
    logic slew;
    sdi_tap_pkg::seq_state_t seq;
    logic [sdi_tap_pkg::CODE_W-1:0] code;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;
  logic [3:0][DW-1:0] ins_w;
  logic [3:0][DW-1:0] ret_w;

  cadence_if cad ();

  assign ins_w = {ins_b2_i, ins_b1_i, ins_a2_i, ins_a1_i};
  assign ret_w = {link_b_stream2_return_i, link_b_stream1_return_i,
                  link_a_stream2_return_i, link_a_stream1_return_i};
  assign cad.ce = tx_ce_i;
  assign cad.sd_mode = (tx_mode_i == sdi_tap_pkg::MODE_SD);

  ce_cadence_check u_cadence (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .cif(cad)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.slew = (tx_mode_i == sdi_tap_pkg::MODE_SD);
    if (tx_ce_i) begin
      s_nxt.tap = ins_w;
      // select and word move together so no word is split at a switch
      s_nxt.sel = use_return_i;
      s_nxt.tx = use_return_i ? ret_w : ins_w;
    end
    if (s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_fail_i) begin
      // a failure wins over a same-cycle reset or start so it is never lost
      s_nxt.seq = sdi_tap_pkg::SEQ_FAIL;
      s_nxt.code = seq_fail_code_i;
    end else if (full_reset_i) begin
      s_nxt.seq = sdi_tap_pkg::SEQ_IDLE;
      s_nxt.code = sdi_tap_pkg::CODE_NONE;
    end else if (seq_start_i) begin
      s_nxt.seq = sdi_tap_pkg::SEQ_BUSY;
      s_nxt.code = sdi_tap_pkg::CODE_NONE;
    end else begin
      case (s_r.seq)
        sdi_tap_pkg::SEQ_BUSY: begin
          if (seq_ok_i) begin
            s_nxt.seq = sdi_tap_pkg::SEQ_DONE;
          end
        end
        sdi_tap_pkg::SEQ_IDLE, sdi_tap_pkg::SEQ_DONE, sdi_tap_pkg::SEQ_FAIL: begin
          // a failure stays latched: late events cannot mask it
        end
        default: begin
          s_nxt.seq = sdi_tap_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link_a_stream1_tap_o = s_r.tap[0];
  assign link_a_stream2_tap_o = s_r.tap[1];
  assign link_b_stream1_tap_o = s_r.tap[2];
  assign link_b_stream2_tap_o = s_r.tap[3];
  assign tx_a1_o = s_r.tx[0];
  assign tx_a2_o = s_r.tx[1];
  assign tx_b1_o = s_r.tx[2];
  assign tx_b2_o = s_r.tx[3];
  assign use_return_o = s_r.sel;
  assign ce_align_err_o = cad.err;
  assign slew_o = s_r.slew;
  assign change_done_o = (s_r.seq == sdi_tap_pkg::SEQ_DONE);
  assign change_fail_o = (s_r.seq == sdi_tap_pkg::SEQ_FAIL);
  assign change_fail_code_o = s_r.code;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  tap_a1_a: assert property (tx_ce_i |=> link_a_stream1_tap_o == $past(ins_a1_i))
    else $error("link A stream 1 tap wrong");
  tap_a2_a: assert property (tx_ce_i |=> link_a_stream2_tap_o == $past(ins_a2_i))
    else $error("link A stream 2 tap wrong");
  tap_b1_a: assert property (tx_ce_i |=> link_b_stream1_tap_o == $past(ins_b1_i))
    else $error("link B stream 1 tap wrong");
  tap_b2_hold_a: assert property (!tx_ce_i |=> $stable(link_b_stream2_tap_o))
    else $error("link B stream 2 tap moved without enable");
  src_return_a: assert property (tx_ce_i && use_return_i
      |=> tx_a1_o == $past(link_a_stream1_return_i) &&
          tx_b2_o == $past(link_b_stream2_return_i))
    else $error("returned streams not sent");
  src_internal_a: assert property (tx_ce_i && !use_return_i
      |=> tx_a2_o == $past(ins_a2_i) && tx_b1_o == $past(ins_b1_i))
    else $error("internal streams not sent");
  sel_switch_a: assert property (!tx_ce_i |=> $stable(use_return_o) && $stable(tx_a1_o))
    else $error("source switched off an enabled cycle");
  slew_mode_a: assert property (##1 slew_o == ($past(tx_mode_i) == sdi_tap_pkg::MODE_SD))
    else $error("slew control does not follow sd mode");
  done_start_a: assert property ((seq_start_i || full_reset_i) &&
      !(s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_fail_i)
      |=> !change_done_o && !change_fail_o)
    else $error("done or fail high after start or reset");
  fail_code_a: assert property (s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_fail_i
      |=> change_fail_o && change_fail_code_o == $past(seq_fail_code_i))
    else $error("failure not reported with its code");
  fail_hold_a: assert property (change_fail_o && !full_reset_i && !seq_start_i
      |=> change_fail_o && $stable(change_fail_code_o))
    else $error("failure state not held");

  // remaining lanes and status transitions
  tap_b2_a: assert property (tx_ce_i
      |=> link_b_stream2_tap_o == $past(ins_b2_i))
    else $error("link B stream 2 tap wrong");
  tap_hold_a: assert property (!tx_ce_i
      |=> $stable(link_a_stream1_tap_o) && $stable(link_a_stream2_tap_o) &&
          $stable(link_b_stream1_tap_o))
    else $error("tap moved without enable");
  src_return_b_a: assert property (tx_ce_i && use_return_i
      |=> tx_a2_o == $past(link_a_stream2_return_i) &&
          tx_b1_o == $past(link_b_stream1_return_i))
    else $error("returned link A 2 or link B 1 not sent");
  src_internal_b_a: assert property (tx_ce_i && !use_return_i
      |=> tx_a1_o == $past(ins_a1_i) &&
          tx_b2_o == $past(ins_b2_i))
    else $error("internal link A 1 or link B 2 not sent");
  sel_follow_a: assert property (tx_ce_i
      |=> use_return_o == $past(use_return_i))
    else $error("select not taken on enabled cycle");
  tx_hold_a: assert property (!tx_ce_i
      |=> $stable(tx_a2_o) && $stable(tx_b1_o) &&
          $stable(tx_b2_o))
    else $error("sent word moved without enable");
  done_ok_a: assert property (s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_ok_i
      && !seq_fail_i && !full_reset_i && !seq_start_i
      |=> change_done_o && !change_fail_o)
    else $error("successful sequence not reported done");
  done_hold_a: assert property (change_done_o && !seq_start_i && !full_reset_i
      |=> change_done_o)
    else $error("done dropped without a new sequence");
  fail_rise_a: assert property (!(s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_fail_i)
      |=> !$rose(change_fail_o))
    else $error("fail raised without a failed sequence");
  fail_clear_a: assert property (full_reset_i
      && !(s_r.seq == sdi_tap_pkg::SEQ_BUSY && seq_fail_i)
      |=> !change_fail_o && change_fail_code_o == sdi_tap_pkg::CODE_NONE)
    else $error("full reset did not clear failure");
  code_idle_a: assert property (!change_fail_o
      |-> change_fail_code_o == sdi_tap_pkg::CODE_NONE)
    else $error("failure code shown while fail low");
endmodule : sdi_tx_stream_tap_status

// [logic/sdi_tap_pkg.sv]
// shared constants for the transmit stream tap and status block
package sdi_tap_pkg;
  localparam int DATA_W = 10;
  localparam int MODE_W = 3;
  localparam int CODE_W = 3;
  // transmit mode encoding
  localparam logic [MODE_W-1:0] MODE_HD = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SD = 3'h1;
  localparam logic [MODE_W-1:0] MODE_3GA = 3'h2;
  localparam logic [MODE_W-1:0] MODE_3GB_DL = 3'h3;
  localparam logic [MODE_W-1:0] MODE_3GB_DS = 3'h4;
  localparam logic [MODE_W-1:0] MODE_HD_DL = 3'h5;
  // clock-enable cadence, in core clock cycles between enables
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CE_SHORT = 3'h5;
  localparam logic [CNT_W-1:0] CE_LONG = 3'h6;
  localparam logic [CNT_W-1:0] CE_CNT_MAX = 3'h7;
  localparam logic [CNT_W-1:0] CE_CNT_FIRST = 3'h1;
  localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
  // sequence tracker, gray coded along idle-busy-done
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_BUSY = 2'h1,
    SEQ_DONE = 2'h3,
    SEQ_FAIL = 2'h2
  } seq_state_t;
endpackage : sdi_tap_pkg

// [logic/cadence_if.sv]
// carrier between the stream block and its cadence checker
`timescale 1ns/1ps
interface cadence_if;
  logic ce;
  logic sd_mode;
  logic err;
  modport checker_side (input ce, input sd_mode, output err);
  modport user_side (output ce, output sd_mode, input err);
endinterface : cadence_if

// [logic/ce_cadence_check.sv]
// checks the alternating 5/6 cycle clock-enable cadence in sd mode
`timescale 1ns/1ps
module ce_cadence_check (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // cadence carrier
  cadence_if.checker_side cif
);
  typedef struct packed {
    logic [sdi_tap_pkg::CNT_W-1:0] cnt;
    logic seen_ce;
    logic has_prev;
    logic long_prev;
    logic err;
  } cad_state_t;

  cad_state_t s_r;
  cad_state_t s_nxt;
  logic bad;

  always_comb begin
    s_nxt = s_r;
    bad = 1'b0;
    if (!cif.sd_mode) begin
      // outside sd mode the flag means nothing, so hold it low and rearm
      s_nxt = '0;
    end else if (cif.ce) begin
      if (s_r.has_prev) begin
        bad = !((s_r.cnt == sdi_tap_pkg::CE_SHORT && s_r.long_prev) ||
                (s_r.cnt == sdi_tap_pkg::CE_LONG && !s_r.long_prev));
      end else begin
        bad = !(s_r.cnt == sdi_tap_pkg::CE_SHORT || s_r.cnt == sdi_tap_pkg::CE_LONG);
      end
      if (s_r.seen_ce) begin
        s_nxt.err = bad;
        s_nxt.has_prev = 1'b1;
        s_nxt.long_prev = (s_r.cnt == sdi_tap_pkg::CE_LONG);
      end
      s_nxt.seen_ce = 1'b1;
      s_nxt.cnt = sdi_tap_pkg::CE_CNT_FIRST;
    end else if (s_r.cnt != sdi_tap_pkg::CE_CNT_MAX) begin
      s_nxt.cnt = s_r.cnt + sdi_tap_pkg::CE_CNT_FIRST;
    end else if (s_r.seen_ce) begin
      // enable overdue: a missing pulse is a cadence fault too
      s_nxt.err = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cif.err = s_r.err;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  cad_off_low_a: assert property (!cif.sd_mode |=> !cif.err)
    else $error("cadence error raised outside sd mode");
  cad_repeat_a: assert property (cif.sd_mode && cif.ce && s_r.has_prev &&
      s_r.cnt == sdi_tap_pkg::CE_SHORT && !s_r.long_prev |=> cif.err)
    else $error("two short intervals not flagged");
  cad_good_a: assert property (cif.sd_mode && cif.ce && s_r.has_prev &&
      s_r.cnt == sdi_tap_pkg::CE_LONG && !s_r.long_prev |=> !cif.err)
    else $error("good alternation flagged as error");
endmodule : ce_cadence_check

// [verification/anc_insert_model.sv]
// ancillary insertion model facing the stream taps
`timescale 1ns/1ps
module anc_insert_model #(
  parameter logic [9:0] MARK = 10'h155
) (
  // insertion request
  input wire logic insert_en_i,
  // taps in, returns out
  input wire logic [9:0] tap_i [4],
  output logic [9:0] ret_o [4],
  output logic use_return_o
);
  // marks every word so a returned word never equals its tap
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      ret_o[k] = tap_i[k] ^ MARK;
    end
  end
  assign use_return_o = insert_en_i;
endmodule : anc_insert_model

// [verification/test_sdi_tx_stream_tap_status.sv]
// testbench for the transmit stream tap and status block
`timescale 1ns/1ps
module test_sdi_tx_stream_tap_status;
  logic core_clk_i, arst_n_i, tx_ce_i, insert_en, use_ret, use_ret_o;
  logic [2:0] tx_mode_i;
  logic [9:0] ins [4];
  logic [9:0] tap [4];
  logic [9:0] ret [4];
  logic [9:0] txw [4];
  logic seq_start, seq_ok, seq_fail, full_reset, err, slew, done, fail;
  logic [2:0] fcode, code;
  int error_cnt, tests_run;
  sdi_tx_stream_tap_status sdi_tx_stream_tap_status_i (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .tx_ce_i(tx_ce_i), .tx_mode_i(tx_mode_i), .ins_a1_i(ins[0]),
    .ins_a2_i(ins[1]), .ins_b1_i(ins[2]), .ins_b2_i(ins[3]),
    .link_a_stream1_tap_o(tap[0]), .link_a_stream2_tap_o(tap[1]),
    .link_b_stream1_tap_o(tap[2]), .link_b_stream2_tap_o(tap[3]), .use_return_i(use_ret),
    .link_a_stream1_return_i(ret[0]), .link_a_stream2_return_i(ret[1]),
    .link_b_stream1_return_i(ret[2]), .link_b_stream2_return_i(ret[3]),
    .tx_a1_o(txw[0]), .tx_a2_o(txw[1]), .tx_b1_o(txw[2]), .tx_b2_o(txw[3]),
    .use_return_o(use_ret_o), .seq_start_i(seq_start), .seq_ok_i(seq_ok),
    .seq_fail_i(seq_fail), .seq_fail_code_i(fcode), .full_reset_i(full_reset),
    .ce_align_err_o(err), .slew_o(slew), .change_done_o(done), .change_fail_o(fail),
    .change_fail_code_o(code));
  anc_insert_model anc_insert_model_i (.insert_en_i(insert_en), .tap_i(tap), .ret_o(ret),
    .use_return_o(use_ret));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  // one enabled word, inputs move 1 ns after the edge
  task automatic ce_pulse();
    tx_ce_i = 1'b1;
    tick(1);
    tx_ce_i = 1'b0;
  endtask : ce_pulse
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic set_ins(input logic [9:0] base);
    for (int k = 0; k < 4; k++) ins[k] = base + 10'(k);
  endtask : set_ins
  task automatic t_streams();
    insert_en = 1'b0;
    set_ins(10'h2a0);
    ce_pulse();
    for (int k = 0; k < 4; k++) begin
      chk("tap", ins[k], tap[k]);
      chk("tx internal", ins[k], txw[k]);
    end
    insert_en = 1'b1;
    set_ins(10'h0c8);
    ce_pulse();
    for (int k = 0; k < 4; k++) chk("tx return", (10'h2a0 + 10'(k)) ^ 10'h155, txw[k]);
    chk("select", 10'h001, {9'h000, use_ret_o});
    insert_en = 1'b0;
    tick(3);
    chk("select held", 10'h001, {9'h000, use_ret_o});
    ce_pulse();
    chk("select off", 10'h000, {9'h000, use_ret_o});
    for (int k = 0; k < 4; k++) chk("tx ignores return", ins[k], txw[k]);
  endtask : t_streams
  task automatic t_slew();
    for (int m = 0; m < 6; m++) begin
      tx_mode_i = 3'(m);
      tick(1);
      chk("slew", {9'h000, tx_mode_i == sdi_tap_pkg::MODE_SD}, {9'h000, slew});
    end
  endtask : t_slew
  // intervals 5, 6, 5 keep the cadence; a second 5 breaks it
  task automatic t_cadence();
    tx_mode_i = sdi_tap_pkg::MODE_SD;
    tick(2);
    ce_pulse();
    tick(4);
    ce_pulse();
    tick(5);
    ce_pulse();
    tick(4);
    ce_pulse();
    tick(1);
    chk("cadence ok", 10'h000, {9'h000, err});
    tick(3);
    ce_pulse();
    tick(1);
    chk("cadence bad", 10'h001, {9'h000, err});
    tx_mode_i = sdi_tap_pkg::MODE_HD;
    tick(2);
    chk("cadence outside sd", 10'h000, {9'h000, err});
  endtask : t_cadence
  task automatic t_seq();
    chk("fail idle", 10'h000, {9'h000, fail});
    seq_start = 1'b1;
    tick(1);
    seq_start = 1'b0;
    chk("done busy", 10'h000, {9'h000, done});
    seq_ok = 1'b1;
    tick(1);
    seq_ok = 1'b0;
    chk("done ok", 10'h001, {9'h000, done});
    seq_start = 1'b1;
    tick(1);
    seq_start = 1'b0;
    chk("done restart", 10'h000, {9'h000, done});
    seq_fail = 1'b1;
    fcode = 3'h5;
    tick(1);
    seq_fail = 1'b0;
    fcode = 3'h2;
    chk("fail", 10'h001, {9'h000, fail});
    chk("code", 10'h005, {7'h00, code});
    seq_ok = 1'b1;
    tick(3);
    seq_ok = 1'b0;
    chk("code held", 10'h005, {7'h00, code});
    chk("fail held", 10'h001, {9'h000, fail});
    full_reset = 1'b1;
    tick(1);
    full_reset = 1'b0;
    chk("fail cleared", 10'h000, {6'h00, fail, code});
    seq_start = 1'b1;
    tick(1);
    seq_start = 1'b0;
    {seq_fail, full_reset} = 2'b11;
    fcode = 3'h3;
    tick(1);
    {seq_fail, full_reset} = 2'b00;
    chk("fail over reset", 10'h00b, {6'h00, fail, code});
    seq_start = 1'b1;
    tick(1);
    seq_start = 1'b0;
    chk("fail cleared by start", 10'h000, {5'h00, done, fail, code});
  endtask : t_seq
  initial begin
    {arst_n_i, tx_ce_i, insert_en, seq_start, seq_ok, seq_fail, full_reset} = '0;
    tx_mode_i = sdi_tap_pkg::MODE_HD;
    fcode = 3'h0;
    error_cnt = 0;
    tests_run = 0;
    set_ins(10'h000);
    tick(8);
    arst_n_i = 1'b1;
    t_streams();
    t_slew();
    t_cadence();
    t_seq();
    wrap_up();
  end
endmodule : test_sdi_tx_stream_tap_status
